//--- design/ucbg_top.sv
`timescale 1ns/1ps

// Operation
// - Pins serial only with enable and directions set
// - Async full duplex, synchronous modes half duplex
// - Nine-bit selects pick frame length per direction
// - Single receive starts one master reception
// - Single receive clears itself after completion
// - Async continuous receive enables reception
// - Sync continuous receive runs, overrides single
// - Framing flag read-only, updated with next byte
// - Overrun flag read-only, cleared via continuous
// - Ninth received bit kept for software
// - Free-running 8-bit timer makes baud clock
// - High-speed select matters only in async
// - Clock source: master when set, else slave
// - Bit 3 of both registers reads zero
// - Bit period 64, 16 or 4 times (X+1)
// - Divisor write resets the baud timer
// - Async receive level by three-sample majority vote
module ucbg_top #(
	parameter int DIV_W = 8
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [ucbg_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [1:0] port_pin_direction,
	input wire logic tx_ck_i,
	output logic tx_ck_o,
	output logic tx_ck_oe,
	input wire logic rx_dt_i,
	output logic rx_dt_o,
	output logic rx_dt_oe
);

	// ==========================================================
	// Declarations.
	logic wait_ff, nxt_wait;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [7:0] tx_cs_ff, nxt_tx_cs;
	logic [7:0] rx_cs_ff, nxt_rx_cs;
	logic [DIV_W-1:0] baud_ff, nxt_baud;
	logic [7:0] txbuf_ff, nxt_txbuf;
	logic txfull_ff, nxt_txfull;
	logic [7:0] rxbuf_ff, nxt_rxbuf;
	logic rxvalid_ff, nxt_rxvalid;
	logic rx_ninth_data_ff, nxt_rx_ninth_data;
	logic framing_error_flag_ff, nxt_framing_error_flag;
	logic overrun_error_flag_ff, nxt_overrun_error_flag;
	logic [1:0] s1_ff, s2_ff, s3_ff, flt_ff, prev_ff;
	logic [1:0] nxt_flt;
	ucbg_pkg::ucbg_tx_state_t tx_st_ff, nxt_tx_st;
	logic [8:0] tx_sh_ff, nxt_tx_sh;
	logic [3:0] tx_cnt_ff, nxt_tx_cnt;
	logic tx_line_ff, nxt_tx_line;
	ucbg_pkg::ucbg_rx_state_t rx_st_ff, nxt_rx_st;
	logic [8:0] rx_sh_ff, nxt_rx_sh;
	logic [3:0] rx_cnt_ff, nxt_rx_cnt;
	logic [5:0] rx_ph_ff, nxt_rx_ph;
	logic [1:0] votes_ff, nxt_votes;
	logic ck_o_ff, ck_oe_ff, dt_o_ff, dt_oe_ff;
	logic nxt_ck_o, nxt_ck_oe, nxt_dt_o, nxt_dt_oe;
	logic acc, map_ok, wr_en, rd_en, rx_pop, baud_wr;
	logic [7:0] idx, rd_val;
	logic pin_en, sync_m, master, continuous_receive_enable, single_receive_enable, rx_on, tx_ok;
	logic [5:0] div_m1, mid;
	logic [ucbg_pkg::PH_W-1:0] phase;
	logic unit_tick, step, shift_reg_empty, tx_load, tx_adv;
	logic ck_rise, ck_fall, dt_fall, rx_done, rx_framing_error_flag, rx_bit;
	logic [3:0] bits_tx, bits_rx;

	// ==========================================================
	// Mode decode.
	assign pin_en = rx_cs_ff[ucbg_pkg::B_PORT_EN]
		& (port_pin_direction == 2'h3);
	assign sync_m = tx_cs_ff[ucbg_pkg::B_SYNC_MODE];
	assign master = sync_m & tx_cs_ff[ucbg_pkg::B_CLK_SRC];
	assign continuous_receive_enable = rx_cs_ff[ucbg_pkg::B_CONT_RX];
	assign single_receive_enable = rx_cs_ff[ucbg_pkg::B_SINGLE_RX];
	// Single receive only counts for a master; overrun halts reception.
	assign rx_on = pin_en & ~overrun_error_flag_ff & (continuous_receive_enable | (master & single_receive_enable));
	// In a synchronous mode the line is shared, so receive wins.
	assign tx_ok = pin_en & tx_cs_ff[ucbg_pkg::B_TX_EN]
		& ~(sync_m & rx_on);
	assign div_m1 = sync_m ? ucbg_pkg::DIV_SYNC_M1
		: (tx_cs_ff[ucbg_pkg::B_HI_SPEED] ? ucbg_pkg::DIV_ASYNC_HI_M1
		: ucbg_pkg::DIV_ASYNC_LO_M1);
	assign mid = {1'b0, div_m1[5:1]} + 6'h01;
	assign step = unit_tick & (phase == '0);
	assign bits_tx = tx_cs_ff[ucbg_pkg::B_TX_NINE] ? ucbg_pkg::BITS9_M1
		: ucbg_pkg::BITS8_M1;
	assign bits_rx = rx_cs_ff[ucbg_pkg::B_RX_NINE] ? ucbg_pkg::BITS9_M1
		: ucbg_pkg::BITS8_M1;
	assign shift_reg_empty = (tx_st_ff == ucbg_pkg::TX_IDLE);
	assign ck_rise = flt_ff[0] & ~prev_ff[0];
	assign ck_fall = ~flt_ff[0] & prev_ff[0];
	assign dt_fall = ~flt_ff[1] & prev_ff[1];

	ucbg_baud_gen #(
		.DIV_W(DIV_W),
		.PH_W(ucbg_pkg::PH_W)
	) u_baud (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.divisor(baud_ff),
		.divisor_wr(baud_wr),
		.phase_last(div_m1),
		.unit_tick(unit_tick),
		.phase(phase)
	);

	// ==========================================================
	// Bus slave. Every access is answered with waitrequest low one
	// cycle after it is first seen; the access acts at that edge.
	assign acc = (avs_read | avs_write) & wait_ff;
	assign idx = avs_address[ucbg_pkg::ADDR_W-1:2];
	assign map_ok = (avs_address[1:0] == 2'h0);
	assign wr_en = acc & avs_write & avs_byteenable[0] & map_ok;
	assign rd_en = acc & avs_read & map_ok;
	assign rx_pop = rd_en & (idx == ucbg_pkg::IDX_RX_DATA);
	assign baud_wr = wr_en & (idx == ucbg_pkg::IDX_BAUD);

	always_comb
	begin
		rd_val = 8'h00;
		case (idx)
			ucbg_pkg::IDX_TX_CS:
			begin
				rd_val = tx_cs_ff;
				rd_val[ucbg_pkg::B_SHIFT_EMPTY] = shift_reg_empty;
			end
			ucbg_pkg::IDX_RX_CS:
			begin
				rd_val = rx_cs_ff;
				rd_val[ucbg_pkg::B_FRAME_ERR] = framing_error_flag_ff;
				rd_val[ucbg_pkg::B_OVERRUN] = overrun_error_flag_ff;
				rd_val[ucbg_pkg::B_RX_NINTH_D] = rx_ninth_data_ff;
			end
			ucbg_pkg::IDX_BAUD: rd_val = baud_ff;
			ucbg_pkg::IDX_TX_DATA: rd_val = txbuf_ff;
			ucbg_pkg::IDX_RX_DATA: rd_val = rxbuf_ff;
			ucbg_pkg::IDX_STATUS:
			begin
				rd_val[ucbg_pkg::B_ST_RX_VALID] = rxvalid_ff;
				rd_val[ucbg_pkg::B_ST_TX_EMPTY] = ~txfull_ff;
			end
			default: rd_val = 8'h00;
		endcase
	end

	always_comb
	begin
		nxt_wait = ~acc;
		nxt_rdata = rdata_ff;
		nxt_tx_cs = tx_cs_ff;
		nxt_rx_cs = rx_cs_ff;
		nxt_baud = baud_ff;
		nxt_txbuf = txbuf_ff;
		nxt_txfull = txfull_ff & ~tx_load;
		nxt_rxbuf = rxbuf_ff;
		nxt_rxvalid = rxvalid_ff & ~rx_pop;
		nxt_rx_ninth_data = rx_ninth_data_ff;
		nxt_framing_error_flag = framing_error_flag_ff;
		nxt_overrun_error_flag = overrun_error_flag_ff;
		if (acc)
			nxt_rdata = rd_en ? {24'h000000, rd_val} : 32'h00000000;
		if (rx_done & master & ~continuous_receive_enable)
			nxt_rx_cs[ucbg_pkg::B_SINGLE_RX] = 1'b0;
		if (wr_en)
		begin
			case (idx)
				ucbg_pkg::IDX_TX_CS:
					nxt_tx_cs = avs_writedata[7:0]
						& ucbg_pkg::TX_CS_WMASK;
				ucbg_pkg::IDX_RX_CS:
				begin
					nxt_rx_cs = avs_writedata[7:0]
						& ucbg_pkg::RX_CS_WMASK;
					if (!avs_writedata[ucbg_pkg::B_CONT_RX])
						nxt_overrun_error_flag = 1'b0;
				end
				ucbg_pkg::IDX_BAUD: nxt_baud = avs_writedata[DIV_W-1:0];
				ucbg_pkg::IDX_TX_DATA:
				begin
					nxt_txbuf = avs_writedata[7:0];
					nxt_txfull = 1'b1;
				end
				default: nxt_baud = baud_ff;
			endcase
		end
		// A finished frame may land in the very cycle the buffer is read.
		if (rx_done)
		begin
			if (rxvalid_ff & ~rx_pop)
				nxt_overrun_error_flag = 1'b1;
			else
			begin
				nxt_rxvalid = 1'b1;
				nxt_framing_error_flag = rx_framing_error_flag;
				if (rx_cs_ff[ucbg_pkg::B_RX_NINE])
				begin
					nxt_rxbuf = nxt_rx_sh[7:0];
					nxt_rx_ninth_data = nxt_rx_sh[8];
				end
				else
				begin
					nxt_rxbuf = nxt_rx_sh[8:1];
					nxt_rx_ninth_data = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wait_ff <= 1'b1;
			rdata_ff <= '0;
			tx_cs_ff <= ucbg_pkg::TX_CS_RST & ucbg_pkg::TX_CS_WMASK;
			rx_cs_ff <= ucbg_pkg::RX_CS_RST & ucbg_pkg::RX_CS_WMASK;
			baud_ff <= ucbg_pkg::BAUD_RST;
			txbuf_ff <= '0;
			txfull_ff <= 1'b0;
			rxbuf_ff <= '0;
			rxvalid_ff <= 1'b0;
			rx_ninth_data_ff <= 1'b0;
			framing_error_flag_ff <= 1'b0;
			overrun_error_flag_ff <= 1'b0;
		end
		else
		begin
			wait_ff <= nxt_wait;
			rdata_ff <= nxt_rdata;
			tx_cs_ff <= nxt_tx_cs;
			rx_cs_ff <= nxt_rx_cs;
			baud_ff <= nxt_baud;
			txbuf_ff <= nxt_txbuf;
			txfull_ff <= nxt_txfull;
			rxbuf_ff <= nxt_rxbuf;
			rxvalid_ff <= nxt_rxvalid;
			rx_ninth_data_ff <= nxt_rx_ninth_data;
			framing_error_flag_ff <= nxt_framing_error_flag;
			overrun_error_flag_ff <= nxt_overrun_error_flag;
		end
	end

	// ==========================================================
	// Pin input synchronisers, bit 0 clock pin, bit 1 data pin.
	// The filtered level moves only when stages two and three agree.
	always_comb
	begin
		nxt_flt = (s2_ff & s3_ff) | (flt_ff & (s2_ff | s3_ff));
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s1_ff <= 2'h3;
			s2_ff <= 2'h3;
			s3_ff <= 2'h3;
			flt_ff <= 2'h3;
			prev_ff <= 2'h3;
		end
		else
		begin
			s1_ff <= {rx_dt_i, tx_ck_i};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			flt_ff <= nxt_flt;
			prev_ff <= flt_ff;
		end
	end

	// ==========================================================
	// Transmitter. A slave presents its first bit at once and moves
	// on each falling clock; the other modes move on baud steps.
	assign tx_adv = (sync_m & ~master) ? ck_fall : step;

	always_comb
	begin
		nxt_tx_st = tx_st_ff;
		nxt_tx_sh = tx_sh_ff;
		nxt_tx_cnt = tx_cnt_ff;
		nxt_tx_line = tx_line_ff;
		tx_load = 1'b0;
		unique case (tx_st_ff)
			ucbg_pkg::TX_IDLE:
			begin
				if (txfull_ff & tx_ok & (tx_adv | (sync_m & ~master)))
				begin
					tx_load = 1'b1;
					nxt_tx_sh = {tx_cs_ff[ucbg_pkg::B_TX_NINTH_D],
						txbuf_ff};
					nxt_tx_cnt = bits_tx;
					nxt_tx_st = sync_m ? ucbg_pkg::TX_SHIFT
						: ucbg_pkg::TX_START;
					nxt_tx_line = sync_m & txbuf_ff[0];
				end
			end
			ucbg_pkg::TX_START:
			begin
				if (tx_adv)
				begin
					nxt_tx_st = ucbg_pkg::TX_SHIFT;
					nxt_tx_line = tx_sh_ff[0];
				end
			end
			ucbg_pkg::TX_SHIFT:
			begin
				if (tx_adv && tx_cnt_ff == 4'h0)
				begin
					nxt_tx_st = sync_m ? ucbg_pkg::TX_IDLE
						: ucbg_pkg::TX_STOP;
					nxt_tx_line = ucbg_pkg::LINE_IDLE;
				end
				else if (tx_adv)
				begin
					nxt_tx_sh = {1'b0, tx_sh_ff[8:1]};
					nxt_tx_line = tx_sh_ff[1];
					nxt_tx_cnt = tx_cnt_ff - 4'h1;
				end
			end
			ucbg_pkg::TX_STOP:
			begin
				if (tx_adv)
					nxt_tx_st = ucbg_pkg::TX_IDLE;
			end
		endcase
		if (!tx_ok && tx_st_ff != ucbg_pkg::TX_IDLE)
		begin
			nxt_tx_st = ucbg_pkg::TX_IDLE;
			nxt_tx_line = ucbg_pkg::LINE_IDLE;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tx_st_ff <= ucbg_pkg::TX_IDLE;
			tx_sh_ff <= '0;
			tx_cnt_ff <= '0;
			tx_line_ff <= ucbg_pkg::LINE_IDLE;
		end
		else
		begin
			tx_st_ff <= nxt_tx_st;
			tx_sh_ff <= nxt_tx_sh;
			tx_cnt_ff <= nxt_tx_cnt;
			tx_line_ff <= nxt_tx_line;
		end
	end

	// ==========================================================
	// Receiver. Async bits are timed from the start edge by counting
	// baud ticks; synchronous bits are taken at the clock high phase.
	assign rx_bit = sync_m ? flt_ff[1] : votes_ff[1];

	always_comb
	begin
		nxt_rx_st = rx_st_ff;
		nxt_rx_sh = rx_sh_ff;
		nxt_rx_cnt = rx_cnt_ff;
		nxt_rx_ph = rx_ph_ff;
		nxt_votes = votes_ff;
		rx_done = 1'b0;
		rx_framing_error_flag = 1'b0;
		if (unit_tick && rx_st_ff != ucbg_pkg::RX_IDLE)
		begin
			if (rx_ph_ff == div_m1)
			begin
				nxt_rx_ph = '0;
				nxt_votes = '0;
			end
			else
			begin
				nxt_rx_ph = rx_ph_ff + 6'h01;
				if (rx_ph_ff + 6'h01 >= mid && rx_ph_ff <= mid + 6'h01)
					nxt_votes = votes_ff + {1'b0, flt_ff[1]};
			end
		end
		unique case (rx_st_ff)
			ucbg_pkg::RX_IDLE:
			begin
				nxt_rx_ph = '0;
				nxt_votes = '0;
				if (rx_on & ~sync_m & dt_fall)
					nxt_rx_st = ucbg_pkg::RX_START;
				else if (rx_on & sync_m & (~master | step))
				begin
					nxt_rx_st = ucbg_pkg::RX_DATA;
					nxt_rx_cnt = bits_rx;
				end
			end
			ucbg_pkg::RX_START:
			begin
				if (unit_tick && rx_ph_ff == div_m1)
				begin
					nxt_rx_st = votes_ff[1] ? ucbg_pkg::RX_IDLE
						: ucbg_pkg::RX_DATA;
					nxt_rx_cnt = bits_rx;
				end
			end
			ucbg_pkg::RX_DATA:
			begin
				if (sync_m ? (master ? (unit_tick
					&& phase == ucbg_pkg::SYNC_SAMPLE_PH) : ck_rise)
					: (unit_tick && rx_ph_ff == div_m1))
				begin
					nxt_rx_sh = {rx_bit, rx_sh_ff[8:1]};
					nxt_rx_cnt = rx_cnt_ff - 4'h1;
					if (rx_cnt_ff == 4'h0)
					begin
						nxt_rx_st = sync_m ? ucbg_pkg::RX_IDLE
							: ucbg_pkg::RX_STOP;
						rx_done = sync_m;
					end
				end
			end
			ucbg_pkg::RX_STOP:
			begin
				if (unit_tick && rx_ph_ff == div_m1)
				begin
					nxt_rx_st = ucbg_pkg::RX_IDLE;
					rx_done = 1'b1;
					rx_framing_error_flag = ~votes_ff[1];
				end
			end
		endcase
		if (!rx_on && rx_st_ff != ucbg_pkg::RX_IDLE)
		begin
			nxt_rx_st = ucbg_pkg::RX_IDLE;
			rx_done = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_st_ff <= ucbg_pkg::RX_IDLE;
			rx_sh_ff <= '0;
			rx_cnt_ff <= '0;
			rx_ph_ff <= '0;
			votes_ff <= '0;
		end
		else
		begin
			rx_st_ff <= nxt_rx_st;
			rx_sh_ff <= nxt_rx_sh;
			rx_cnt_ff <= nxt_rx_cnt;
			rx_ph_ff <= nxt_rx_ph;
			votes_ff <= nxt_votes;
		end
	end

	// ==========================================================
	// Pin drivers. The master clock idles low and runs only while a
	// frame is on the line, high in the last two phases of a bit.
	always_comb
	begin
		nxt_ck_oe = pin_en & (~sync_m | master);
		// A pulse already high runs to the end of its bit, since a
		// reception ends at the phase three sample, in mid-pulse.
		nxt_ck_o = sync_m ? (phase[1] & master
			& ((tx_st_ff == ucbg_pkg::TX_SHIFT)
			| (rx_st_ff == ucbg_pkg::RX_DATA)
			| (ck_o_ff & (phase == ucbg_pkg::SYNC_SAMPLE_PH))))
			: tx_line_ff;
		nxt_dt_oe = pin_en & sync_m & ~shift_reg_empty;
		nxt_dt_o = tx_line_ff;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ck_o_ff <= ucbg_pkg::LINE_IDLE;
			ck_oe_ff <= 1'b0;
			dt_o_ff <= ucbg_pkg::LINE_IDLE;
			dt_oe_ff <= 1'b0;
		end
		else
		begin
			ck_o_ff <= nxt_ck_o;
			ck_oe_ff <= nxt_ck_oe;
			dt_o_ff <= nxt_dt_o;
			dt_oe_ff <= nxt_dt_oe;
		end
	end

	assign avs_readdata = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign tx_ck_o = ck_o_ff;
	assign tx_ck_oe = ck_oe_ff;
	assign rx_dt_o = dt_o_ff;
	assign rx_dt_oe = dt_oe_ff;

endmodule : ucbg_top

//--- include/ucbg_pkg.sv
package ucbg_pkg;

	// ==========================================================
	// Register map, word indices; byte address is four times.
	localparam int ADDR_W = 10;
	localparam logic [7:0] IDX_RX_CS = 8'h18;
	localparam logic [7:0] IDX_TX_CS = 8'h98;
	localparam logic [7:0] IDX_BAUD = 8'h99;
	localparam logic [7:0] IDX_TX_DATA = 8'h19;
	localparam logic [7:0] IDX_RX_DATA = 8'h1a;
	localparam logic [7:0] IDX_STATUS = 8'h1b;

	// ==========================================================
	// Field positions.
	localparam int B_CLK_SRC = 7;
	localparam int B_TX_NINE = 6;
	localparam int B_TX_EN = 5;
	localparam int B_SYNC_MODE = 4;
	localparam int B_HI_SPEED = 2;
	localparam int B_SHIFT_EMPTY = 1;
	localparam int B_TX_NINTH_D = 0;
	localparam int B_PORT_EN = 7;
	localparam int B_RX_NINE = 6;
	localparam int B_SINGLE_RX = 5;
	localparam int B_CONT_RX = 4;
	localparam int B_FRAME_ERR = 2;
	localparam int B_OVERRUN = 1;
	localparam int B_RX_NINTH_D = 0;
	localparam int B_ST_RX_VALID = 0;
	localparam int B_ST_TX_EMPTY = 1;

	// ==========================================================
	// Writable bits and values after reset.
	localparam logic [7:0] TX_CS_WMASK = 8'hf5;
	localparam logic [7:0] RX_CS_WMASK = 8'hf0;
	localparam logic [7:0] TX_CS_RST = 8'h02;
	localparam logic [7:0] RX_CS_RST = 8'h00;
	localparam logic [7:0] BAUD_RST = 8'h00;
	localparam logic LINE_IDLE = 1'b1;

	// ==========================================================
	// Baud phases per bit, minus one, and frame lengths minus one.
	localparam int PH_W = 6;
	localparam logic [5:0] DIV_ASYNC_LO_M1 = 6'h3f;
	localparam logic [5:0] DIV_ASYNC_HI_M1 = 6'h0f;
	localparam logic [5:0] DIV_SYNC_M1 = 6'h03;
	localparam logic [5:0] SYNC_SAMPLE_PH = 6'h03;
	localparam logic [3:0] BITS8_M1 = 4'h7;
	localparam logic [3:0] BITS9_M1 = 4'h8;

	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_START = 4'h2,
		TX_SHIFT = 4'h4,
		TX_STOP = 4'h8
	} ucbg_tx_state_t;

	typedef enum logic [3:0] {
		RX_IDLE = 4'h1,
		RX_START = 4'h2,
		RX_DATA = 4'h4,
		RX_STOP = 4'h8
	} ucbg_rx_state_t;

endpackage : ucbg_pkg

//--- design/ucbg_baud_gen.sv
`timescale 1ns/1ps

module ucbg_baud_gen #(
	parameter int DIV_W = 8,
	parameter int PH_W = 6
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [DIV_W-1:0] divisor,
	input wire logic divisor_wr,
	input wire logic [PH_W-1:0] phase_last,
	output logic unit_tick,
	output logic [PH_W-1:0] phase
);

	logic [DIV_W-1:0] cnt_ff;
	logic [DIV_W-1:0] nxt_cnt;
	logic tick_ff;
	logic nxt_tick;
	logic [PH_W-1:0] ph_ff;
	logic [PH_W-1:0] nxt_ph;

	// ==========================================================
	// Timer and phase counter.
	// Phase and tick change on the same edge, so a tick is seen
	// together with the phase it has just entered.
	always_comb
	begin
		nxt_cnt = cnt_ff + 1'b1;
		nxt_tick = 1'b0;
		nxt_ph = ph_ff;
		if (divisor_wr)
		begin
			nxt_cnt = '0;
			nxt_ph = '0;
		end
		else if (cnt_ff >= divisor)
		begin
			nxt_cnt = '0;
			nxt_tick = 1'b1;
			nxt_ph = (ph_ff >= phase_last) ? '0 : ph_ff + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_ff <= '0;
			tick_ff <= 1'b0;
			ph_ff <= '0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			tick_ff <= nxt_tick;
			ph_ff <= nxt_ph;
		end
	end

	assign unit_tick = tick_ff;
	assign phase = ph_ff;

endmodule : ucbg_baud_gen

//--- testbench/ucbg_top_asserts.sv
`timescale 1ns/1ps

// ==========
// Bus, pin and bit-period checks on the top ports.
module ucbg_top_asserts #(
	parameter int DIV_W = 8
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [ucbg_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [1:0] port_pin_direction,
	input wire logic tx_ck_o,
	input wire logic tx_ck_oe,
	input wire logic rx_dt_oe
);
	logic [7:0] ix;
	logic unm, wr_ok, sync_ff, src_ff, hs_ff, last_ff, ok_ff;
	logic [DIV_W-1:0] baud_ff;
	logic [15:0] run_ff;
	int bit_len;
	assign ix = avs_address[9:2];
	assign unm = avs_address[1:0] != 2'h0 || !(ix inside
		{ucbg_pkg::IDX_RX_CS, ucbg_pkg::IDX_TX_CS, ucbg_pkg::IDX_BAUD,
		ucbg_pkg::IDX_TX_DATA, ucbg_pkg::IDX_RX_DATA, ucbg_pkg::IDX_STATUS});
	assign wr_ok = avs_write && avs_waitrequest && avs_byteenable[0] && !unm;
	assign bit_len = (int'(baud_ff) + 1) * (hs_ff ? 16 : 64);
	// Any write voids the level run being timed, since it may change rate.
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			{sync_ff, src_ff, hs_ff, ok_ff} <= 4'h0;
			last_ff <= 1'b1;
			baud_ff <= '0;
			run_ff <= 16'h0;
		end
		else
		begin
			last_ff <= tx_ck_o;
			run_ff <= (tx_ck_o != last_ff) ? 16'h1 : run_ff + 16'h1;
			ok_ff <= !avs_write && (ok_ff || tx_ck_o != last_ff);
			if (wr_ok && ix == ucbg_pkg::IDX_TX_CS)
				{src_ff, sync_ff, hs_ff} <= {avs_writedata[7],
					avs_writedata[4], avs_writedata[2]};
			if (wr_ok && ix == ucbg_pkg::IDX_BAUD)
				baud_ff <= avs_writedata[DIV_W-1:0];
		end
	end
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_rd;
		avs_read && avs_waitrequest;
	endsequence
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	wait_answer_a: assert property (s_req |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for two cycles");
	read_upper_a: assert property (avs_readdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	unmapped_zero_a: assert property ((s_rd ##0 unm) |=> avs_readdata == 0)
		else $error("unmapped read not zero");
	bit3_zero_a: assert property ((s_rd ##0 (ix == ucbg_pkg::IDX_TX_CS ||
		ix == ucbg_pkg::IDX_RX_CS)) |=> !avs_readdata[3])
		else $error("bit 3 of control register not zero");
	baud_read_a: assert property ((s_rd ##0 (!unm &&
		ix == ucbg_pkg::IDX_BAUD)) |=> avs_readdata[DIV_W-1:0] == baud_ff)
		else $error("divisor read back wrong");
	ck_pin_a: assert property (tx_ck_oe |-> $past(port_pin_direction) == 2'h3)
		else $error("clock pin driven without directions set");
	dt_pin_a: assert property (rx_dt_oe |-> $past(port_pin_direction) == 2'h3)
		else $error("data pin driven without directions set");
	async_bits_a: assert property (tx_ck_oe && !sync_ff && ok_ff &&
		tx_ck_o && !last_ff |-> int'(run_ff) % bit_len == 0)
		else $error("async low run not a whole bit period");
	sync_clock_a: assert property (tx_ck_oe && sync_ff && src_ff && ok_ff &&
		!tx_ck_o && last_ff |-> int'(run_ff) == 2 * (int'(baud_ff) + 1))
		else $error("sync clock high time wrong");
endmodule : ucbg_top_asserts

bind ucbg_top ucbg_top_asserts #(.DIV_W(DIV_W)) u_asserts (
	.ref_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_byteenable,
	.avs_writedata, .avs_readdata, .avs_waitrequest, .port_pin_direction,
	.tx_ck_o, .tx_ck_oe, .rx_dt_oe
);

//--- testbench/ucbg_line_model.sv
`timescale 1ns/1ps

// ==========
// Far-end terminal: decodes async frames, sends async or sync data.
module ucbg_line_model (
	input wire logic ref_clk,
	input wire logic tx_line,
	input wire logic tx_line_oe,
	input wire logic sync,
	input wire logic nine,
	input wire logic [15:0] bit_len,
	output logic rx_line,
	output logic [8:0] got,
	output logic got_stb
);
	logic [8:0] sh, dec;
	initial
	begin
		rx_line = 1'b1;
		got = 9'h0;
		got_stb = 1'b0;
		sh = 9'h0;
		dec = 9'h0;
	end
	always @(negedge tx_line)
	begin
		if (sync)
		begin
			sh <= sh >> 1;
			rx_line <= sh[1];
		end
		else if (tx_line_oe)
		begin
			dec = 9'h0;
			repeat (bit_len / 2) @(posedge ref_clk);
			for (int k = 0; k < (nine ? 9 : 8); k++)
			begin
				repeat (bit_len) @(posedge ref_clk);
				dec[k] = tx_line;
			end
			got <= dec;
			got_stb <= 1'b1;
			@(posedge ref_clk);
			got_stb <= 1'b0;
		end
	end
	// A one-clock glitch per data bit; a single-sample receiver may trip.
	task automatic send(input logic [8:0] d, logic stop, logic glitch);
		rx_line <= 1'b0;
		repeat (bit_len) @(posedge ref_clk);
		for (int k = 0; k < (nine ? 9 : 8); k++)
		begin
			rx_line <= d[k];
			repeat (bit_len / 2) @(posedge ref_clk);
			rx_line <= d[k] ^ glitch;
			@(posedge ref_clk);
			rx_line <= d[k];
			repeat (bit_len / 2 - 1) @(posedge ref_clk);
		end
		rx_line <= stop;
		repeat (bit_len) @(posedge ref_clk);
		rx_line <= 1'b1;
		repeat (bit_len) @(posedge ref_clk);
	endtask : send
	task automatic sync_load(input logic [7:0] d);
		sh <= {1'b0, d};
		rx_line <= d[0];
	endtask : sync_load
endmodule : ucbg_line_model

//--- testbench/testbench.sv
`timescale 1ns/1ps

module testbench;
	logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest, tgl;
	logic tx_ck_i, tx_ck_o, tx_ck_oe, rx_dt_i, rx_dt_o, rx_dt_oe;
	logic line_rx, sync, nine, got_stb;
	logic [ucbg_pkg::ADDR_W-1:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, m;
	logic [1:0] port_pin_direction;
	logic [15:0] blen;
	logic [8:0] got, d;
	logic [7:0] sy;
	logic [31:0] rq_e[$], rq_m[$];
	logic [8:0] txq[$];
	int err_count, tests_run;
	// Undriven clock pin toggles so no settled value is mistaken for data.
	assign tx_ck_i = tx_ck_oe ? tx_ck_o : tgl;
	assign rx_dt_i = rx_dt_oe ? rx_dt_o : line_rx;
	ucbg_top #(.DIV_W(8)) uut (.ref_clk(ref_clk), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_byteenable(4'h1),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.port_pin_direction(port_pin_direction), .tx_ck_i(tx_ck_i),
		.tx_ck_o(tx_ck_o), .tx_ck_oe(tx_ck_oe), .rx_dt_i(rx_dt_i),
		.rx_dt_o(rx_dt_o), .rx_dt_oe(rx_dt_oe));
	ucbg_line_model u_line (.ref_clk(ref_clk), .tx_line(tx_ck_o),
		.tx_line_oe(tx_ck_oe), .sync(sync), .nine(nine), .bit_len(blen),
		.rx_line(line_rx), .got(got), .got_stb(got_stb));
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
		tgl <= !tgl;
	// Far end of a synchronous transmit takes data on the rising clock.
	always @(posedge tx_ck_o)
		if (sync && rx_dt_oe)
			sy <= {rx_dt_o, sy[7:1]};
	task automatic check(input logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report
	task automatic bus(input logic w, logic [7:0] idx, logic [7:0] v);
		int n;
		@(posedge ref_clk);
		avs_address <= {idx, 2'b00};
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, v};
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50)
			check(32'h1, 32'h0);
	endtask : bus
	task automatic wr(input logic [7:0] idx, logic [7:0] v);
		bus(1'b1, idx, v);
	endtask : wr
	task automatic rd(input logic [7:0] idx, logic [31:0] e, logic [31:0] k);
		rq_e.push_back(e);
		rq_m.push_back(k);
		bus(1'b0, idx, 8'h00);
	endtask : rd
	always @(posedge ref_clk)
	begin
		if (avs_read && avs_waitrequest === 1'b0)
		begin
			m = rq_m.pop_front();
			check(avs_readdata & m, rq_e.pop_front() & m);
		end
		if (got_stb === 1'b1)
			check({23'h0, got}, {23'h0, txq.pop_front()});
	end
	initial
	begin
		repeat (40000) @(posedge ref_clk);
		err_count++;
		final_report();
	end
	initial
	begin
		{rst_b, avs_read, avs_write, tgl, sync, nine} = 6'h0;
		avs_address = '0;
		avs_writedata = 32'h0;
		port_pin_direction = 2'h1;
		blen = 16'h40;
		void'($urandom(32'h905864d7));
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(ucbg_pkg::IDX_TX_CS, 32'h02, 32'hff);
		rd(ucbg_pkg::IDX_RX_CS, 32'h00, 32'hfe);
		rd(ucbg_pkg::IDX_BAUD, 32'h00, 32'hff);
		rd(8'h00, 32'h0, 32'hffffffff);
		wr(ucbg_pkg::IDX_TX_CS, 8'h0f);
		rd(ucbg_pkg::IDX_TX_CS, 32'h07, 32'hff);
		d = $urandom;
		wr(ucbg_pkg::IDX_RX_CS, d[7:0] & 8'h4f);
		rd(ucbg_pkg::IDX_RX_CS, {24'h0, d[7:0] & 8'h40}, 32'hfe);
		wr(ucbg_pkg::IDX_BAUD, d[8:1]);
		rd(ucbg_pkg::IDX_BAUD, {24'h0, d[8:1]}, 32'hff);
		$display("test registers done");
		port_pin_direction <= 2'h3;
		// Low speed, high speed with divisor 1, high speed with divisor 0.
		for (int k = 0; k < 3; k++)
		begin
			d = $urandom;
			blen <= (k == 1 ? 16'h2 : 16'h1) * (k == 0 ? 16'h40 : 16'h10);
			nine <= (k == 1);
			wr(ucbg_pkg::IDX_BAUD, (k == 1) ? 8'h01 : 8'h00);
			wr(ucbg_pkg::IDX_RX_CS, 8'h80);
			wr(ucbg_pkg::IDX_TX_CS, {1'b0, k == 1, 3'h4, k != 0, 1'b0, d[8]});
			txq.push_back({d[8] & (k == 1), d[7:0]});
			wr(ucbg_pkg::IDX_TX_DATA, d[7:0]);
			repeat (4 * blen) @(posedge ref_clk);
			rd(ucbg_pkg::IDX_TX_CS, 32'h0, 32'h02);
			repeat (9 * blen) @(posedge ref_clk);
			rd(ucbg_pkg::IDX_TX_CS, 32'h02, 32'h02);
		end
		$display("test async transmit done");
		wr(ucbg_pkg::IDX_TX_CS, 8'h00);
		wr(ucbg_pkg::IDX_BAUD, 8'h00);
		blen <= 16'h40;
		nine <= 1'b1;
		wr(ucbg_pkg::IDX_RX_CS, 8'hd0);
		for (int k = 0; k < 3; k++)
		begin
			d = $urandom;
			u_line.send(d, k != 1, k == 0);
			rd(ucbg_pkg::IDX_STATUS, 32'h1, 32'h1);
			rd(ucbg_pkg::IDX_RX_CS, {29'h0, k == 1, 1'b0, d[8]}, 32'h7);
			rd(ucbg_pkg::IDX_RX_DATA, {24'h0, d[7:0]}, 32'hff);
		end
		u_line.send(9'h155, 1'b1, 1'b0);
		u_line.send(9'h0aa, 1'b1, 1'b0);
		rd(ucbg_pkg::IDX_RX_CS, 32'h02, 32'h02);
		rd(ucbg_pkg::IDX_RX_DATA, 32'h55, 32'hff);
		wr(ucbg_pkg::IDX_RX_CS, 8'hc0);
		rd(ucbg_pkg::IDX_RX_CS, 32'h00, 32'h02);
		u_line.send(9'h0f0, 1'b1, 1'b0);
		rd(ucbg_pkg::IDX_STATUS, 32'h0, 32'h1);
		$display("test async receive done");
		sync <= 1'b1;
		wr(ucbg_pkg::IDX_BAUD, 8'h01);
		wr(ucbg_pkg::IDX_TX_CS, 8'h94);
		wr(ucbg_pkg::IDX_RX_CS, 8'h80);
		d = $urandom;
		u_line.sync_load(d[7:0]);
		wr(ucbg_pkg::IDX_RX_CS, 8'ha0);
		repeat (100) @(posedge ref_clk);
		rd(ucbg_pkg::IDX_RX_CS, 32'h80, 32'hf0);
		rd(ucbg_pkg::IDX_RX_DATA, {24'h0, d[7:0]}, 32'hff);
		$display("test sync receive done");
		d = $urandom;
		wr(ucbg_pkg::IDX_TX_CS, 8'hb4);
		wr(ucbg_pkg::IDX_TX_DATA, d[7:0]);
		repeat (100) @(posedge ref_clk);
		check({24'h0, sy}, {24'h0, d[7:0]});
		rd(ucbg_pkg::IDX_TX_CS, 32'h02, 32'h02);
		$display("test sync transmit done");
		final_report();
	end
endmodule : testbench
